/* rtl/cffc_pkg.sv */
package cffc_pkg;
	// Register byte addresses, one 32-bit word each
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_MASK     = 8'h08;
	localparam logic [7:0] REG_REQ      = 8'h0c;
	localparam logic [7:0] REG_UID_LO   = 8'h10;
	localparam logic [7:0] REG_UID_HI   = 8'h14;
	localparam logic [7:0] REG_FAMILY   = 8'h18;
	// Control fields and reset value
	localparam int          CTRL_SELECTED = 0;
	localparam int          CTRL_ENABLE   = 1;
	localparam int          CTRL_W        = 2;
	localparam logic [1:0]  CTRL_RST      = 2'h2;
	// Status and mask fields
	localparam int          ST_REQ        = 0;
	localparam int          ST_DROP       = 1;
	localparam int          ST_OPT_ERR    = 2;
	localparam int          ST_RSP_DONE   = 3;
	localparam int          ST_W          = 4;
	localparam logic [3:0]  MASK_RST      = 4'h0;
	// Request flag positions, flag n of the byte sits at index n-1
	localparam int          FL_SUBCARRIER = 0;
	localparam int          FL_HIGH_RATE  = 1;
	localparam int          FL_INVENTORY  = 2;
	localparam int          FL_EXTENSION  = 3;
	localparam int          FL_SELECT     = 4;
	localparam int          FL_ADDRESS    = 5;
	localparam int          FL_OPTION     = 6;
	localparam int          FL_FAMILY     = 4;
	localparam int          FL_SLOT_ONE   = 5;
	// Response flags and error codes
	localparam int          RSP_ERROR     = 0;
	localparam logic [7:0]  ERR_OPT_UNSUP = 8'h03;
	// Field sizes
	localparam logic [2:0]  UID_LAST      = 3'h7;
	localparam logic [2:0]  SLOT_LEN_16   = 3'h4;
	localparam logic [2:0]  SLOT_LEN_1    = 3'h0;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	// Reset value of the tag identifier; value is arbitrary
	localparam logic [63:0] UID_RST       = 64'h0123_4567_89ab_cdef;
	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_FLAGS  = 3'b001,
		RX_CMD    = 3'b010,
		RX_FAMILY = 3'b011,
		RX_UID    = 3'b100,
		RX_BODY   = 3'b101
	} cffc_rx_e;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_FLAGS = 3'b001,
		TX_ERR   = 3'b010,
		TX_DATA  = 3'b011,
		TX_EOF   = 3'b100
	} cffc_tx_e;
endpackage : cffc_pkg

/* rtl/cffc_byte_if.sv */
`timescale 1ns/1ps
interface cffc_byte_if;
	logic       valid;
	logic [7:0] data;
	modport src (output valid, output data);
	modport snk (input valid, input data);
endinterface : cffc_byte_if

/* rtl/cffc_lsb_deser.sv */
`timescale 1ns/1ps
module cffc_lsb_deser (
	input  wire logic   i_clk,
	input  wire logic   i_reset,
	input  wire logic   i_clear,
	input  wire logic   i_bit_valid,
	input  wire logic   i_bit,
	cffc_byte_if.src    byte_out
);
	import cffc_pkg::*;

	logic [7:0] shift_ff;
	logic [3:0] count_ff;
	logic [7:0] nxt_shift;
	wire        full;

	// First bit in lands at bit 0 once eight have arrived
	assign nxt_shift = {i_bit, shift_ff[7:1]};
	assign full      = (count_ff == BYTE_BITS - 4'h1);

	always_ff @(posedge i_clk) begin
		if (i_reset || i_clear) begin
			shift_ff       <= 8'h00;
			count_ff       <= 4'h0;
			byte_out.valid <= 1'b0;
			byte_out.data  <= 8'h00;
		end else begin
			byte_out.valid <= i_bit_valid && full;
			if (i_bit_valid) begin
				shift_ff <= nxt_shift;
				count_ff <= full ? 4'h0 : count_ff + 4'h1;
				if (full) begin
					byte_out.data <= nxt_shift;
				end
			end
		end
	end
endmodule : cffc_lsb_deser

/* rtl/cffc_frame_codec.sv */
`timescale 1ns/1ps
// Rules of the document this block works to
// RL1: Request flags are one byte, top reserved
// RL2: Inventory flag picks meaning of upper flags
// RL3: Flag 1 picks one or two subcarriers
// RL4: Flag 2 picks low or high return rate
// RL5: Flag 4 marks extended protocol format
// RL6: Select flag: only Selected tag executes
// RL7: Address flag: UID follows, must match
// RL8: Reader never sends select with address
// RL9: Option flag only outside inventory requests
// RL10: Inventory flag 5: family byte present
// RL11: Inventory flag 6: one or sixteen slots
// RL12: Request: flags, command, fields, CRC, end
// RL13: Response: flags, fields, CRC; no command (code sends flags, then fields, then end, with no CRC)
// RL14: Response flags: extension, reserved all zero
// RL15: Error flag set means error code follows
// RL16: Select plus address answers error 03h
// RL17: Bytes go LSB first, words LSByte first
// RL18: First byte after start is the flags
module cffc_frame_codec (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	output logic             o_irq,
	input  wire logic        i_rx_sof,
	input  wire logic        i_rx_bit_valid,
	input  wire logic        i_rx_bit,
	input  wire logic        i_rx_eof,
	input  wire logic        i_rx_crc_ok,
	output logic             o_two_subcarrier,
	output logic             o_high_rate,
	output logic             o_inventory,
	output logic             o_ext_format,
	output logic             o_select_only,
	output logic             o_addressed,
	output logic             o_option,
	output logic             o_family_field_present,
	output logic             o_single_slot_sel,
	output logic      [2:0]  o_slot_len,
	output logic      [7:0]  o_cmd_code,
	output logic      [7:0]  o_family_id,
	output logic             o_param_valid,
	output logic      [7:0]  o_param_byte,
	output logic             o_exec,
	input  wire logic        i_rsp_start,
	input  wire logic        i_rsp_error,
	input  wire logic [7:0]  i_rsp_err_code,
	input  wire logic        i_rsp_valid,
	input  wire logic [7:0]  i_rsp_data,
	input  wire logic        i_rsp_last,
	output logic             o_rsp_ready,
	output logic             o_rsp_busy,
	output logic             o_tx_sof,
	output logic             o_tx_bit_valid,
	output logic             o_tx_bit,
	input  wire logic        i_tx_bit_ready,
	output logic             o_tx_eof
);
	import cffc_pkg::*;

	cffc_byte_if rx_byte ();

	logic [CTRL_W-1:0] ctrl_ff;
	logic [ST_W-1:0]   status_ff;
	logic [ST_W-1:0]   mask_ff;
	logic [63:0]       uid_ff;
	logic [63:0]       uid_rx_ff;
	logic [2:0]        uid_cnt_ff;
	logic [7:0]        flags_ff;
	cffc_rx_e          rx_state_ff;
	cffc_tx_e          tx_state_ff;
	logic [7:0]        tx_shift_ff;
	logic [3:0]        tx_cnt_ff;
	logic              tx_err_ff;
	logic [7:0]        tx_code_ff;
	logic              tx_last_ff;

	// Bus decode; a write lands on the edge that sees ack high
	wire        wb_req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire        wb_wr     = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we;
	wire        wr_ctrl   = wb_wr && (i_wb_adr == REG_CTRL) && i_wb_sel[0];
	wire        wr_status = wb_wr && (i_wb_adr == REG_STATUS) && i_wb_sel[0];
	wire        wr_mask   = wb_wr && (i_wb_adr == REG_MASK) && i_wb_sel[0];
	wire        wr_uid_lo = wb_wr && (i_wb_adr == REG_UID_LO);
	wire        wr_uid_hi = wb_wr && (i_wb_adr == REG_UID_HI);
	wire        enabled   = ctrl_ff[CTRL_ENABLE];
	logic [31:0] rd_mux;

	always_comb begin
		unique case (i_wb_adr)
		REG_CTRL:   rd_mux = {30'h0, ctrl_ff};
		REG_STATUS: rd_mux = {28'h0, status_ff};
		REG_MASK:   rd_mux = {28'h0, mask_ff};
		REG_REQ:    rd_mux = {16'h0, o_cmd_code, flags_ff};
		REG_UID_LO: rd_mux = uid_ff[31:0];
		REG_UID_HI: rd_mux = uid_ff[63:32];
		REG_FAMILY: rd_mux = {24'h0, o_family_id};
		default:    rd_mux = 32'h0;
		endcase
	end

	// Byte lane merge for the identifier words
	function automatic logic [31:0] lanes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : lanes

	// Unmapped addresses still ack and read zero, so a stray access never hangs
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
			ctrl_ff  <= CTRL_RST;
			mask_ff  <= MASK_RST;
			uid_ff   <= UID_RST;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rd_mux : 32'h0;
			if (wr_ctrl) begin
				ctrl_ff <= i_wb_dat[CTRL_W-1:0];
			end
			if (wr_mask) begin
				mask_ff <= i_wb_dat[ST_W-1:0];
			end
			if (wr_uid_lo) begin
				uid_ff[31:0] <= lanes(uid_ff[31:0], i_wb_dat, i_wb_sel);
			end
			if (wr_uid_hi) begin
				uid_ff[63:32] <= lanes(uid_ff[63:32], i_wb_dat, i_wb_sel);
			end
		end
	end

	// Receive path
	cffc_lsb_deser u_deser (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_clear     (i_rx_sof),
		.i_bit_valid (i_rx_bit_valid && rx_state_ff != RX_IDLE),
		.i_bit       (i_rx_bit),
		.byte_out    (rx_byte.src)
	);

	wire [7:0] rb      = rx_byte.data;
	wire       rb_inv  = rb[FL_INVENTORY]; // RL2
	wire       f_inv   = flags_ff[FL_INVENTORY];
	wire       f_sel   = !f_inv && flags_ff[FL_SELECT];
	wire       f_addr  = !f_inv && flags_ff[FL_ADDRESS];
	wire       f_fam   = f_inv && flags_ff[FL_FAMILY];
	// Optional fields start right after the command code
	wire       need_fam = f_fam; // RL10
	wire       need_uid = f_addr && !f_sel; // RL7
	cffc_rx_e  nxt_after_cmd;
	assign nxt_after_cmd = need_fam ? RX_FAMILY :
		(need_uid ? RX_UID : RX_BODY); // RL12

	// A frame cut short before its body is treated like a bad frame
	wire rx_end    = i_rx_eof && rx_state_ff != RX_IDLE;
	wire hdr_ok    = rx_state_ff == RX_BODY;
	wire frame_ok  = rx_end && hdr_ok && i_rx_crc_ok; // RL12
	wire opt_err   = f_sel && f_addr; // RL16
	wire uid_match = uid_rx_ff == uid_ff; // RL7
	wire who_ok    = f_sel ? ctrl_ff[CTRL_SELECTED] : // RL6
		(f_addr ? uid_match : 1'b1);
	wire accept    = frame_ok && !opt_err && who_ok;
	wire err_start = frame_ok && opt_err; // RL16
	wire dropped   = rx_end && !accept && !err_start;
	wire body_byte = rx_byte.valid && rx_state_ff == RX_BODY;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rx_state_ff   <= RX_IDLE;
			flags_ff      <= 8'h00;
			uid_rx_ff     <= 64'h0;
			uid_cnt_ff    <= 3'h0;
			o_cmd_code    <= 8'h00;
			o_family_id   <= 8'h00;
			o_param_valid <= 1'b0;
			o_param_byte  <= 8'h00;
			o_exec        <= 1'b0;
		end else begin
			o_param_valid <= body_byte;
			o_exec        <= accept;
			if (body_byte) begin
				o_param_byte <= rb;
			end
			if (i_rx_sof && enabled) begin
				rx_state_ff <= RX_FLAGS;
				uid_cnt_ff  <= 3'h0;
			end else if (rx_end) begin
				rx_state_ff <= RX_IDLE;
			end else if (rx_byte.valid) begin
				unique case (rx_state_ff)
				RX_IDLE: begin
					rx_state_ff <= RX_IDLE;
				end
				RX_FLAGS: begin
					flags_ff    <= rb; // RL18
					rx_state_ff <= RX_CMD;
				end
				RX_CMD: begin
					o_cmd_code  <= rb;
					rx_state_ff <= nxt_after_cmd;
				end
				RX_FAMILY: begin
					o_family_id <= rb;
					rx_state_ff <= RX_BODY;
				end
				RX_UID: begin
					uid_rx_ff  <= {rb, uid_rx_ff[63:8]}; // RL17
					uid_cnt_ff <= uid_cnt_ff + 3'h1;
					if (uid_cnt_ff == UID_LAST) begin
						rx_state_ff <= RX_BODY;
					end
				end
				RX_BODY: begin
					rx_state_ff <= RX_BODY;
				end
				default: begin
					rx_state_ff <= RX_IDLE;
				end
				endcase
			end
		end
	end

	// Decoded flags; the reserved top bit is not looked at
	wire take_flags = rx_byte.valid && rx_state_ff == RX_FLAGS; // RL1
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_two_subcarrier       <= 1'b0;
			o_high_rate            <= 1'b0;
			o_inventory            <= 1'b0;
			o_ext_format           <= 1'b0;
			o_select_only          <= 1'b0;
			o_addressed            <= 1'b0;
			o_option               <= 1'b0;
			o_family_field_present <= 1'b0;
			o_single_slot_sel      <= 1'b0;
			o_slot_len             <= SLOT_LEN_16;
		end else if (take_flags) begin
			o_two_subcarrier       <= rb[FL_SUBCARRIER]; // RL3
			o_high_rate            <= rb[FL_HIGH_RATE]; // RL4
			o_inventory            <= rb_inv; // RL2
			o_ext_format           <= rb[FL_EXTENSION]; // RL5
			o_select_only          <= !rb_inv && rb[FL_SELECT]; // RL6
			o_addressed            <= !rb_inv && rb[FL_ADDRESS]; // RL7
			o_option               <= !rb_inv && rb[FL_OPTION]; // RL9
			o_family_field_present <= rb_inv && rb[FL_FAMILY]; // RL10
			o_single_slot_sel      <= rb_inv && rb[FL_SLOT_ONE]; // RL11
			o_slot_len <= (rb_inv && rb[FL_SLOT_ONE]) ?
				SLOT_LEN_1 : SLOT_LEN_16; // RL11
		end
	end

	// Transmit path; the response carries no command code
	wire tx_go    = (tx_state_ff == TX_IDLE) && (i_rsp_start || err_start);
	wire bit_take = o_tx_bit_valid && i_tx_bit_ready;
	wire byte_end = bit_take && (tx_cnt_ff == 4'h1);
	// Error bit only; extension and reserved bits stay zero
	wire [7:0] rsp_flags = {7'h00, tx_err_ff}; // RL14

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_state_ff    <= TX_IDLE;
			tx_shift_ff    <= 8'h00;
			tx_cnt_ff      <= 4'h0;
			tx_err_ff      <= 1'b0;
			tx_code_ff     <= 8'h00;
			tx_last_ff     <= 1'b0;
			o_tx_sof       <= 1'b0;
			o_tx_eof       <= 1'b0;
			o_tx_bit_valid <= 1'b0;
			o_tx_bit       <= 1'b0;
			o_rsp_ready    <= 1'b0;
			o_rsp_busy     <= 1'b0;
		end else begin
			o_tx_sof    <= tx_go;
			o_tx_eof    <= 1'b0;
			o_rsp_ready <= 1'b0;
			if (tx_go) begin
				tx_err_ff      <= err_start || i_rsp_error; // RL15
				tx_code_ff     <= err_start ? ERR_OPT_UNSUP : i_rsp_err_code;
				tx_last_ff     <= 1'b0;
				tx_state_ff    <= TX_FLAGS; // RL13
				tx_shift_ff    <= 8'h00;
				tx_cnt_ff      <= BYTE_BITS;
				o_rsp_busy     <= 1'b1;
				o_tx_bit_valid <= 1'b0;
			end else if (tx_state_ff == TX_FLAGS && tx_cnt_ff == BYTE_BITS &&
				!o_tx_bit_valid) begin
				tx_shift_ff    <= rsp_flags >> 1;
				o_tx_bit       <= rsp_flags[0]; // RL17
				o_tx_bit_valid <= 1'b1;
			end else if (byte_end) begin
				tx_cnt_ff <= BYTE_BITS;
				unique case (tx_state_ff)
				TX_FLAGS: begin
					if (tx_err_ff) begin
						tx_state_ff <= TX_ERR; // RL15
						tx_shift_ff <= tx_code_ff >> 1;
						o_tx_bit    <= tx_code_ff[0];
					end else begin
						tx_state_ff <= TX_DATA;
						o_tx_bit_valid <= 1'b0;
					end
				end
				TX_ERR: begin
					tx_state_ff    <= TX_EOF;
					o_tx_bit_valid <= 1'b0;
				end
				default: begin
					o_tx_bit_valid <= 1'b0;
				end
				endcase
			end else if (bit_take) begin
				tx_cnt_ff   <= tx_cnt_ff - 4'h1;
				o_tx_bit    <= tx_shift_ff[0];
				tx_shift_ff <= tx_shift_ff >> 1;
			end else if (tx_state_ff == TX_DATA && !o_tx_bit_valid) begin
				// Payload waits for the command logic; a stall only delays
				if (tx_last_ff) begin
					tx_state_ff <= TX_EOF;
				end else if (i_rsp_valid && !o_rsp_ready) begin
					tx_shift_ff    <= i_rsp_data >> 1;
					o_tx_bit       <= i_rsp_data[0]; // RL17
					o_tx_bit_valid <= 1'b1;
					tx_last_ff     <= i_rsp_last;
					o_rsp_ready    <= 1'b1;
				end
			end else if (tx_state_ff == TX_EOF) begin
				tx_state_ff <= TX_IDLE;
				o_tx_eof    <= 1'b1;
				o_rsp_busy  <= 1'b0;
			end
		end
	end

	// Status: a new event beats a same-cycle write-one clear
	wire [ST_W-1:0] st_set = {o_tx_eof, err_start, dropped, accept};
	wire [ST_W-1:0] st_clr = wr_status ? i_wb_dat[ST_W-1:0] : 4'h0;
	wire [ST_W-1:0] nxt_status = (status_ff & ~st_clr) | st_set;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			status_ff <= 4'h0;
			o_irq     <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			o_irq     <= |(nxt_status & mask_ff);
		end
	end
endmodule : cffc_frame_codec

/* test/cffc_checker.sv */
`timescale 1ns/1ps
module cffc_checker (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_wb_cyc,
	input wire logic       i_wb_stb,
	input wire logic       o_wb_ack,
	input wire logic       i_rx_eof,
	input wire logic       o_exec,
	input wire logic       o_inventory,
	input wire logic       o_select_only,
	input wire logic       o_addressed,
	input wire logic       o_option,
	input wire logic       o_family_field_present,
	input wire logic       o_single_slot_sel,
	input wire logic [2:0] o_slot_len,
	input wire logic       i_rsp_start,
	input wire logic       o_rsp_busy,
	input wire logic       o_tx_sof,
	input wire logic       o_tx_bit_valid,
	input wire logic       o_tx_bit,
	input wire logic       i_tx_bit_ready,
	input wire logic       o_tx_eof
);
	import cffc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_tx_start;
		o_tx_sof ##1 o_tx_bit_valid;
	endsequence
	property p_wb_ack;
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
	endproperty
	property p_ack_once;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	property p_inv_sel;
		o_inventory |-> !(o_select_only || o_addressed || o_option);
	endproperty
	property p_inv_fam;
		!o_inventory |-> !(o_family_field_present || o_single_slot_sel);
	endproperty
	property p_slot;
		o_slot_len == (o_single_slot_sel ? SLOT_LEN_1 : SLOT_LEN_16);
	endproperty
	property p_tx_start;
		i_rsp_start && !o_rsp_busy |=> s_tx_start;
	endproperty
	// A stalled modulator must see the same bit again
	property p_tx_hold;
		o_tx_bit_valid && !i_tx_bit_ready |=> o_tx_bit_valid && $stable(o_tx_bit);
	endproperty
	property p_exec_eof;
		o_exec |-> $past(i_rx_eof);
	endproperty
	property p_busy_end;
		$fell(o_rsp_busy) |-> o_tx_eof || $past(o_tx_eof);
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack missing");
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	a_inv_sel: assert property (p_inv_sel) else $error("sel in inv");
	a_inv_fam: assert property (p_inv_fam) else $error("fam out inv");
	a_slot: assert property (p_slot) else $error("slot length");
	a_tx_start: assert property (p_tx_start) else $error("tx start");
	a_tx_hold: assert property (p_tx_hold) else $error("bit changed");
	a_exec_eof: assert property (p_exec_eof) else $error("exec early");
	a_busy_end: assert property (p_busy_end) else $error("busy end");
endmodule : cffc_checker
bind cffc_frame_codec cffc_checker u_chk (.*);

/* test/cffc_reader_model.sv */
`timescale 1ns/1ps
module cffc_reader_model (
	input  wire logic i_clk,
	output logic      o_sof,
	output logic      o_bit_valid,
	output logic      o_bit,
	output logic      o_eof,
	output logic      o_ready,
	input  wire logic i_tx_sof,
	input  wire logic i_tx_valid,
	input  wire logic i_tx_bit
);
	logic [7:0] got[$];
	logic [7:0] sh;
	int         nb;
	initial begin
		o_sof = 0;
		o_bit_valid = 0;
		o_bit = 0;
		o_eof = 0;
		o_ready = 0;
	end
	task send(input logic [7:0] q[$]);
		@(posedge i_clk);
		o_sof <= 1;
		@(posedge i_clk);
		o_sof <= 0;
		foreach (q[i]) for (int b = 0; b < 8; b++) begin
			o_bit_valid <= 1;
			o_bit <= q[i][b];
			@(posedge i_clk);
		end
		o_bit_valid <= 0;
		o_bit <= ~o_bit;
		o_eof <= 1;
		@(posedge i_clk);
		o_eof <= 0;
	endtask : send
	// Random stalls exercise the hold of an offered bit
	always @(posedge i_clk) begin
		o_ready <= ($urandom_range(3) != 0);
		if (i_tx_sof)
			nb = 0;
		if (i_tx_valid && o_ready) begin
			sh = {i_tx_bit, sh[7:1]};
			nb++;
			if (nb % 8 == 0)
				got.push_back(sh);
		end
	end
endmodule : cffc_reader_model

/* test/contactless_frame_flag_codec_bench.sv */
`timescale 1ns/1ps
module contactless_frame_flag_codec_bench;
	import cffc_pkg::*;
	logic        i_clk = 0, i_reset = 1, i_wb_cyc = 0, i_wb_stb = 0;
	logic        i_wb_we = 0, i_rx_crc_ok = 1, i_rsp_start = 0;
	logic        i_rsp_error = 0, i_rsp_valid = 0, i_rsp_last = 0;
	logic [7:0]  i_wb_adr = 0, i_rsp_err_code = 0, i_rsp_data = 0;
	logic [3:0]  i_wb_sel = 4'hf;
	logic [31:0] i_wb_dat = 0, o_wb_dat, rd;
	logic        o_wb_ack, o_irq, i_rx_sof, i_rx_bit_valid, i_rx_bit;
	logic        i_rx_eof, o_two_subcarrier, o_high_rate, o_inventory;
	logic        o_ext_format, o_select_only, o_addressed, o_option;
	logic        o_family_field_present, o_single_slot_sel, o_param_valid;
	logic        o_exec, o_rsp_ready, o_rsp_busy, o_tx_sof, o_tx_bit_valid;
	logic        o_tx_bit, i_tx_bit_ready, o_tx_eof, tag_sel = 1;
	logic [2:0]  o_slot_len;
	logic [7:0]  o_cmd_code, o_family_id, o_param_byte, par0, f;
	int          err_total = 0, checks_done = 0, n_exec = 0, n_par = 0;
	logic [7:0]  fl_list [6] = '{8'h04, 8'h34, 8'h20, 8'h10, 8'h4f, 8'h5b};
	cffc_frame_codec uut (.*);
	cffc_reader_model rdr (.i_clk(i_clk), .o_sof(i_rx_sof),
		.o_bit_valid(i_rx_bit_valid), .o_bit(i_rx_bit), .o_eof(i_rx_eof),
		.o_ready(i_tx_bit_ready), .i_tx_sof(o_tx_sof),
		.i_tx_valid(o_tx_bit_valid), .i_tx_bit(o_tx_bit));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (o_exec === 1'b1)
			n_exec++;
		if (o_param_valid === 1'b1) begin
			if (n_par == 0)
				par0 = o_param_byte;
			n_par++;
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_wb_cyc <= 1;
		i_wb_stb <= 1;
		i_wb_we <= we;
		i_wb_adr <= a;
		i_wb_dat <= d;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		if (o_wb_ack !== 1'b1) begin
			err_total++;
			stop_test();
		end
		rd = o_wb_dat;
		i_wb_cyc <= 0;
		i_wb_stb <= 0;
	endtask : wb
	task wait_rsp;
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
			if (o_rsp_ready === 1'b1)
				i_rsp_valid <= 0;
		end while ((o_rsp_busy !== 1'b0 || rdr.got.size() < 2) && n < 400);
		if (n >= 400) begin
			err_total++;
			stop_test();
		end
		i_rsp_valid <= 0;
		chk(rdr.got.size(), 2);
	endtask : wait_rsp
	function automatic logic [8:0] exp_fl(input logic [7:0] x);
		logic v;
		v = x[2];
		return {x[0], x[1], v, x[3], x[4] & ~v, x[5] & ~v, x[6] & ~v,
			x[4] & v, x[5] & v};
	endfunction : exp_fl
	task frame(input logic [7:0] fl, input logic [7:0] bad);
		logic [7:0] q[$];
		logic [7:0] cmd, fam, b0;
		logic       err, ok;
		int         e0;
		cmd = $urandom;
		fam = $urandom;
		b0 = $urandom;
		err = fl[4] && fl[5] && !fl[2];
		q = {fl, cmd};
		if (fl[2] && fl[4])
			q.push_back(fam);
		if (!fl[2] && fl[5] && !fl[4])
			for (int i = 0; i < 8; i++)
				q.push_back(UID_RST[i*8 +: 8] ^ bad);
		q.push_back(b0);
		q.push_back($urandom);
		e0 = n_exec;
		n_par = 0;
		rdr.got.delete();
		rdr.send(q);
		ok = !err && bad == 0 && i_rx_crc_ok && (fl[2] || !fl[4] || tag_sel);
		repeat (3) @(posedge i_clk);
		chk({o_two_subcarrier, o_high_rate, o_inventory, o_ext_format,
			o_select_only, o_addressed, o_option, o_family_field_present,
			o_single_slot_sel}, exp_fl(fl));
		chk(o_slot_len, fl[2] && fl[5] ? SLOT_LEN_1 : SLOT_LEN_16);
		chk(o_cmd_code, cmd);
		wb(0, REG_REQ, 0);
		chk(rd, {16'h0, cmd, fl});
		if (fl[2] && fl[4])
			chk(o_family_id, fam);
		chk(n_exec - e0, ok);
		if (ok) begin
			chk(n_par, 2);
			chk(par0, b0);
		end
		if (err) begin
			wait_rsp();
			chk({rdr.got[0], rdr.got[1]}, {8'h01, ERR_OPT_UNSUP});
			wb(0, REG_STATUS, 0);
			chk(rd[ST_OPT_ERR], 1);
		end
	endtask : frame
	task rsp(input logic err, input logic [7:0] code, input logic [7:0] d);
		rdr.got.delete();
		@(posedge i_clk);
		i_rsp_start <= 1;
		i_rsp_error <= err;
		i_rsp_err_code <= code;
		i_rsp_valid <= 1;
		i_rsp_data <= d;
		i_rsp_last <= 1;
		@(posedge i_clk);
		i_rsp_start <= 0;
		wait_rsp();
		chk(rdr.got[0], {7'h0, err});
		chk(rdr.got[1], err ? code : d);
	endtask : rsp
	initial begin
		void'($urandom(32'h7495));
		repeat (12) @(posedge i_clk);
		i_reset <= 0;
		wb(0, REG_CTRL, 0);
		chk(rd, CTRL_RST);
		wb(0, REG_MASK, 0);
		chk(rd, MASK_RST);
		wb(0, REG_UID_HI, 0);
		chk(rd, UID_RST[63:32]);
		wb(1, 8'h40, 32'hffff_ffff);
		wb(0, 8'h40, 0);
		chk(rd, 0);
		wb(1, REG_CTRL, 32'h3);
		wb(1, REG_MASK, 32'hf);
		foreach (fl_list[i])
			frame(fl_list[i], 0);
		chk(o_irq, 1);
		wb(1, REG_STATUS, 32'hf);
		wb(0, REG_STATUS, 0);
		chk(rd, 0);
		chk(o_irq, 0);
		wb(1, REG_MASK, 0);
		frame(8'h20, 8'h01);
		frame(8'h30, 0);
		wb(1, REG_CTRL, 32'h2);
		tag_sel = 0;
		frame(8'h10, 0);
		wb(1, REG_CTRL, 32'h3);
		tag_sel = 1;
		i_rx_crc_ok <= 0;
		frame(8'h00, 0);
		i_rx_crc_ok <= 1;
		chk(o_irq, 0);
		for (int i = 0; i < 12; i++) begin
			f = $urandom;
			f[7] = 0;
			if (!f[2] && f[4])
				f[5] = 0;
			frame(f, 0);
			rsp(f[0], $urandom, $urandom);
		end
		stop_test();
	end
endmodule : contactless_frame_flag_codec_bench
